// ---- verilog/rsc_regs.sv ----
`timescale 1ns/1ps
module rsc_regs (
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   // Register port
   input  wire logic [7:0]      reg_addr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [7:0]           reg_rdata,
   // Reference and PLL1 status from the analog core
   input  wire logic [3:0]      ref_active,
   input  wire logic [1:0]      ref_sel,
   input  wire logic            pll1_locked,
   // Reference input controls
   output logic [3:0]           ref_input_powerdown,
   output logic                 ref_loss_mask,
   // PLL1 lock indications
   output logic                 pll1_lock_loss_live,
   output logic                 pll1_lock_loss_sticky,
   output logic                 lock_pin,
   // SYSREF controls
   output rsc_pkg::rsc_sysref_s sysref_cfg,
   output logic                 sysref_request_pulse,
   // Interrupt
   output logic                 irq
);

   //------------------------------------------------------------
   // Bus capture
   //------------------------------------------------------------
   rsc_pkg::rsc_bus_s bus;
   assign bus.addr  = reg_addr;
   assign bus.wdata = reg_wdata;
   assign bus.wr    = reg_wr;
   assign bus.rd    = reg_rd;

   //------------------------------------------------------------
   // Configuration registers
   //------------------------------------------------------------
   logic [7:0] ref_ctrl_q;
   logic [7:0] sr_pwr_div_q;
   logic [7:0] sr_bias_q;
   logic [7:0] sr_pulse_q;
   logic [7:0] sr_phase_q;
   logic [1:0] sr_trig_q;
   logic [1:0] irq_mask_q;

   // Reference control: all inputs enabled, mask clear at reset
   rsc_rw_reg #(.W(8), .ADR(rsc_pkg::OFF_REF_CTRL), .RST(rsc_pkg::RST_REF_CTRL)) u_ref (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata),
      .wr      (bus.wr),
      .value_q (ref_ctrl_q)
   );

   // SYSREF power-down cleared at reset
   rsc_rw_reg #(.W(8), .ADR(rsc_pkg::OFF_SR_PWR_DIV), .RST(rsc_pkg::RST_SR_PWR_DIV)) u_srpd (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata),
      .wr      (bus.wr),
      .value_q (sr_pwr_div_q)
   );

   rsc_rw_reg #(.W(8), .ADR(rsc_pkg::OFF_SR_BIAS_REL), .RST(rsc_pkg::RST_SR_BIAS_REL)) u_srb (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata),
      .wr      (bus.wr),
      .value_q (sr_bias_q)
   );

   rsc_rw_reg #(.W(8), .ADR(rsc_pkg::OFF_SR_PULSE_CNT), .RST(rsc_pkg::RST_ZERO)) u_srpc (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata),
      .wr      (bus.wr),
      .value_q (sr_pulse_q)
   );

   rsc_rw_reg #(.W(8), .ADR(rsc_pkg::OFF_SR_PHASE_DLY), .RST(rsc_pkg::RST_ZERO)) u_srph (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata),
      .wr      (bus.wr),
      .value_q (sr_phase_q)
   );

   // Trigger bits occupy the low two bits; the rest are reserved
   rsc_rw_reg #(.W(2), .ADR(rsc_pkg::OFF_SR_TRIG), .RST(2'h0)) u_srtr (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata[1:0]),
      .wr      (bus.wr),
      .value_q (sr_trig_q)
   );

   rsc_rw_reg #(.W(2), .ADR(rsc_pkg::OFF_IRQ_MASK), .RST(2'h0)) u_msk (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .addr    (bus.addr),
      .wdata   (bus.wdata[1:0]),
      .wr      (bus.wr),
      .value_q (irq_mask_q)
   );

   //------------------------------------------------------------
   // Field decode
   //------------------------------------------------------------
   // Bit n = 1 powers input n down and disables it
   assign ref_input_powerdown = ref_ctrl_q[rsc_pkg::REF_PD_LSB +: 4];
   assign ref_loss_mask       = ref_ctrl_q[rsc_pkg::REF_MASK_BIT];

   // One bit powers down every SYSREF function
   assign sysref_cfg.powerdown    = sr_pwr_div_q[rsc_pkg::SR_PD_BIT];
   assign sysref_cfg.freq_divider = sr_pwr_div_q[6:0];
   assign sysref_cfg.bias_release = sr_bias_q;
   assign sysref_cfg.pulse_count  = sr_pulse_q;
   assign sysref_cfg.phase_delay  = sr_phase_q;
   // Triggers are gated off while SYSREF is powered down
   assign sysref_cfg.trigger_gen  = sr_trig_q[rsc_pkg::SR_TRIG_GEN] & ~sysref_cfg.powerdown;
   assign sysref_cfg.trigger_out  = sr_trig_q[rsc_pkg::SR_TRIG_OUT] & ~sysref_cfg.powerdown;
   assign sysref_cfg.request      = sysref_request_pulse;

   //------------------------------------------------------------
   // SYSREF request: self-clearing one-cycle strobe
   //------------------------------------------------------------
   logic req_q;
   // Not held so software needs no second write to re-arm
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         req_q <= 1'b0;
      end else begin
         req_q <= bus.wr && bus.addr == rsc_pkg::OFF_SR_REQ
                  && bus.wdata[rsc_pkg::SR_REQ_BIT] && !sr_pwr_div_q[rsc_pkg::SR_PD_BIT];
      end
   end
   assign sysref_request_pulse = req_q;

   //------------------------------------------------------------
   // Lock-loss qualification
   //------------------------------------------------------------
   logic sel_inactive;
   logic loss_d;
   logic loss_q;
   logic lock_fail_q;

   // Inactivity counts for the selected input; a powered-down selected input counts as inactive
   assign sel_inactive = ~ref_active[ref_sel] | ref_input_powerdown[ref_sel];

   // Mask clear: lock loss or inactivity; mask set: lock loss only
   assign loss_d = ~pll1_locked | (sel_inactive & ~ref_loss_mask);

   // Registered indication and lock pin
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         loss_q      <= 1'b0;
         lock_fail_q <= 1'b0;
      end else begin
         loss_q      <= loss_d;
         lock_fail_q <= loss_d;
      end
   end

   assign pll1_lock_loss_live = loss_q;
   assign lock_pin            = ~lock_fail_q;

   //------------------------------------------------------------
   // Interrupt status
   //------------------------------------------------------------
   logic       loss_prev_q;
   logic       inact_prev_q;
   logic [1:0] ev;
   logic [1:0] stat_q;
   logic [1:0] clr;

   // Edge detect on the qualified lock-loss indication and the unmasked selected-input inactivity
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         loss_prev_q  <= 1'b0;
         inact_prev_q <= 1'b0;
      end else begin
         loss_prev_q  <= loss_q;
         inact_prev_q <= sel_inactive;
      end
   end

   assign ev[rsc_pkg::IRQ_LOCK_LOSS] = loss_q & ~loss_prev_q;
   assign ev[rsc_pkg::IRQ_REF_LOSS]  = sel_inactive & ~inact_prev_q;
   assign clr = (bus.wr && bus.addr == rsc_pkg::OFF_IRQ_STAT) ? bus.wdata[1:0] : 2'h0;

   for (genvar i = 0; i < 2; i++) begin : g_stk
      rsc_sticky u_stk (
         .ref_clk (ref_clk),
         .rstn    (rstn),
         .set     (ev[i]),
         .clr     (clr[i]),
         .flag_q  (stat_q[i])
      );
   end

   // Sticky lock loss view follows the status bit
   assign pll1_lock_loss_sticky = stat_q[rsc_pkg::IRQ_LOCK_LOSS];
   assign irq                   = |(stat_q & irq_mask_q);

   //------------------------------------------------------------
   // Read data, valid the cycle after the strobe
   //------------------------------------------------------------
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // Unmapped and reserved bits read zero
   always_comb begin
      rdata_d = 8'h00;
      unique case (bus.addr)
         rsc_pkg::OFF_SR_PWR_DIV:   rdata_d = sr_pwr_div_q;
         rsc_pkg::OFF_SR_BIAS_REL:  rdata_d = sr_bias_q;
         rsc_pkg::OFF_SR_PULSE_CNT: rdata_d = sr_pulse_q;
         rsc_pkg::OFF_SR_PHASE_DLY: rdata_d = sr_phase_q;
         rsc_pkg::OFF_SR_TRIG:      rdata_d = {6'h00, sr_trig_q};
         rsc_pkg::OFF_REF_CTRL:     rdata_d = {3'h0, ref_ctrl_q[4:0]};
         rsc_pkg::OFF_IRQ_STAT:     rdata_d = {6'h00, stat_q};
         rsc_pkg::OFF_IRQ_MASK:     rdata_d = {6'h00, irq_mask_q};
         rsc_pkg::OFF_LIVE_STAT:    rdata_d = {5'h00, ~pll1_locked, sel_inactive, loss_q};
         default:                   rdata_d = 8'h00;
      endcase
   end

   // Holds zero outside the answer cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= bus.rd ? rdata_d : 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

endmodule : rsc_regs

// ---- inc/rsc_pkg.sv ----
// What this block does
// - Four reference input power-down bits; 0 keeps input enabled, 1 powers it down.
// - Mask clear: PLL1 lock-loss indications fire on lock loss or selected-input inactivity.
// - Mask set: PLL1 lock-loss indications fire only on genuine lock loss.
// - Mask set also keeps reference inactivity off the lock-detect output pin.
// - SYSREF power-down bit at 1 powers down all SYSREF circuitry.
package rsc_pkg;

   //------------------------------------------------------------
   // Register offsets (byte addresses on the register port)
   //------------------------------------------------------------
   localparam logic [7:0] OFF_SR_PWR_DIV   = 8'h18;
   localparam logic [7:0] OFF_SR_BIAS_REL  = 8'h19;
   localparam logic [7:0] OFF_SR_PULSE_CNT = 8'h1A;
   localparam logic [7:0] OFF_SR_PHASE_DLY = 8'h1B;
   localparam logic [7:0] OFF_SR_TRIG      = 8'h1C;
   localparam logic [7:0] OFF_SR_REQ       = 8'h70;
   localparam logic [7:0] OFF_REF_CTRL     = 8'h80;
   localparam logic [7:0] OFF_IRQ_STAT     = 8'h81;
   localparam logic [7:0] OFF_IRQ_MASK     = 8'h82;
   localparam logic [7:0] OFF_LIVE_STAT    = 8'h83;

   //------------------------------------------------------------
   // Field positions
   //------------------------------------------------------------
   localparam int REF_PD_LSB     = 0;   // ref_input_powerdown[3:0] in reference control
   localparam int REF_MASK_BIT   = 4;   // ref_loss_mask
   localparam int SR_PD_BIT      = 7;   // sysref_powerdown
   localparam int SR_TRIG_GEN    = 1;
   localparam int SR_TRIG_OUT    = 0;
   localparam int SR_REQ_BIT     = 7;
   localparam int IRQ_LOCK_LOSS  = 0;   // Lock-loss indication rose
   localparam int IRQ_REF_LOSS   = 1;   // Selected input went inactive

   //------------------------------------------------------------
   // Reset values
   //------------------------------------------------------------
   localparam logic [7:0] RST_SR_PWR_DIV   = 8'h2F;
   localparam logic [7:0] RST_SR_BIAS_REL  = 8'h81;
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] RST_REF_CTRL     = 8'h00;

   //------------------------------------------------------------
   // Carriers
   //------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rsc_bus_s;

   typedef struct packed {
      logic       powerdown;
      logic [6:0] freq_divider;
      logic [7:0] bias_release;
      logic [7:0] pulse_count;
      logic [7:0] phase_delay;
      logic       trigger_gen;
      logic       trigger_out;
      logic       request;
   } rsc_sysref_s;

endpackage : rsc_pkg

// ---- verilog/rsc_rw_reg.sv ----
`timescale 1ns/1ps
// One software-writable register with reset value
module rsc_rw_reg #(
   parameter int         W   = 8,
   parameter logic [7:0] ADR = 8'h00,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   // Write port
   input  wire logic [7:0]   addr,
   input  wire logic [W-1:0] wdata,
   input  wire logic         wr,
   // Stored value
   output logic [W-1:0]      value_q
);

   // Write on address match
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         value_q <= RST;
      end else if (wr && addr == ADR) begin
         value_q <= wdata;
      end
   end

endmodule : rsc_rw_reg

// ---- verilog/rsc_sticky.sv ----
`timescale 1ns/1ps
// Sticky event bit, write-one-to-clear; a same-cycle event wins
module rsc_sticky (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Set and clear
   input  wire logic set,
   input  wire logic clr,
   // Flag
   output logic      flag_q
);

   // Set has priority so no event is lost during a clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end

endmodule : rsc_sticky

// ---- verif/rsc_regs_sva.sv ----
`timescale 1ns/1ps
module rsc_regs_chk (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 rstn,
   // Register port
   input wire logic [7:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_rdata,
   // Reference and lock status
   input wire logic [3:0]           ref_active,
   input wire logic [1:0]           ref_sel,
   input wire logic                 pll1_locked,
   input wire logic [3:0]           ref_input_powerdown,
   input wire logic                 ref_loss_mask,
   input wire logic                 pll1_lock_loss_live,
   input wire logic                 pll1_lock_loss_sticky,
   input wire logic                 lock_pin,
   // SYSREF
   input wire rsc_pkg::rsc_sysref_s sysref_cfg,
   input wire logic                 sysref_request_pulse
);
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // A powered-down selected input counts as a lost reference
   wire sel_lost = !ref_active[ref_sel] || ref_input_powerdown[ref_sel];
   wire req_wr   = reg_wr && reg_addr == rsc_pkg::OFF_SR_REQ && reg_wdata[7];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   //------------------------------------------------------------
   // Properties
   //------------------------------------------------------------
   ref_pd_write_a : assert property (reg_wr && reg_addr == rsc_pkg::OFF_REF_CTRL |=>
      {4'h0, ref_input_powerdown} == ($past(reg_wdata) & 8'h0F)) else $error("pd write lost");
   ref_ctrl_read_a : assert property (reg_rd && reg_addr == rsc_pkg::OFF_REF_CTRL |=>
      reg_rdata == {3'h0, ref_loss_mask, ref_input_powerdown}) else $error("ref ctrl read");
   loss_unmasked_a : assert property (!ref_loss_mask && sel_lost |=>
      pll1_lock_loss_live) else $error("unmasked ref loss not flagged");
   sticky_set_a : assert property ($rose(pll1_lock_loss_live) |=>
      pll1_lock_loss_sticky) else $error("sticky not set");
   mask_blocks_a : assert property (ref_loss_mask && pll1_locked |=>
      !pll1_lock_loss_live) else $error("masked ref loss flagged");
   lock_loss_a : assert property (!pll1_locked |=> pll1_lock_loss_live)
      else $error("lock loss not flagged");
   lock_pin_a : assert property (lock_pin != pll1_lock_loss_live)
      else $error("lock pin disagrees");
   sr_pd_trig_a : assert property (sysref_cfg.powerdown |->
      !sysref_cfg.trigger_gen && !sysref_cfg.trigger_out) else $error("trigger while down");
   sr_request_a : assert property (req_wr && !sysref_cfg.powerdown |=>
      sysref_request_pulse ##1 !sysref_request_pulse) else $error("request pulse");
   sr_req_down_a : assert property (req_wr && sysref_cfg.powerdown |=>
      !sysref_request_pulse) else $error("request while down");
   reset_vals_a : assert property ($rose(rstn) |-> ref_input_powerdown == 4'h0 &&
      !ref_loss_mask && !sysref_cfg.powerdown) else $error("reset values");
endmodule : rsc_regs_chk

bind rsc_regs rsc_regs_chk i_rsc_regs_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .ref_active, .ref_sel, .pll1_locked, .ref_input_powerdown,
   .ref_loss_mask, .pll1_lock_loss_live, .pll1_lock_loss_sticky, .lock_pin, .sysref_cfg,
   .sysref_request_pulse);

// ---- verif/ref_input_and_sysref_ctrl_regs_tb_top.sv ----
`timescale 1ns/1ps
module ref_input_and_sysref_ctrl_regs_tb_top;
   //------------------------------------------------------------
   // Signals
   //------------------------------------------------------------
   logic                 ref_clk     = 1'b0;
   logic                 rstn        = 1'b0;
   logic [7:0]           reg_addr    = 8'h00;
   logic [7:0]           reg_wdata   = 8'h00;
   logic                 reg_wr      = 1'b0;
   logic                 reg_rd      = 1'b0;
   logic [3:0]           ref_active  = 4'hF;
   logic [1:0]           ref_sel     = 2'h0;
   logic                 pll1_locked = 1'b1;
   logic [7:0]           reg_rdata;
   logic [3:0]           pd;
   logic                 mask, live, sticky, lock_pin, req, irq;
   rsc_pkg::rsc_sysref_s sr;
   int                   errors      = 0;
   int                   check_count = 0;

   // 25 ns period
   always #12.5 ref_clk = ~ref_clk;

   rsc_regs i_rsc_regs (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ref_active, .ref_sel, .pll1_locked, .ref_input_powerdown(pd), .ref_loss_mask(mask),
      .pll1_lock_loss_live(live), .pll1_lock_loss_sticky(sticky), .lock_pin(lock_pin),
      .sysref_cfg(sr), .sysref_request_pulse(req), .irq(irq));

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Strobes go low at the sampling edge, so every access leaves one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_reset;
      chk({3'h0, mask, pd}, 8'h00);
      chk({6'h0, sr.powerdown, lock_pin}, 8'h01);
      rd(8'h18, 8'h2F);
      rd(8'h19, 8'h81);
      rd(8'h1A, 8'h00);
      rd(8'h1C, 8'h00);
      rd(8'h80, 8'h00);
      rd(8'h82, 8'h00);
   endtask : t_reset

   task automatic t_ref_pd;
      for (int i = 0; i < 4; i++) begin
         wr(8'h80, 8'h01 << i);
         chk({4'h0, pd}, 8'h01 << i);
         rd(8'h80, 8'h01 << i);
      end
      wr(8'h80, 8'h00);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      rd(8'h80, 8'h00);
   endtask : t_ref_pd

   task automatic t_irq;
      wr(8'h81, 8'hFF);
      rd(8'h81, 8'h00);
      wr(8'h82, 8'h01);
      @(posedge ref_clk);
      pll1_locked <= 1'b0;
      step(2);
      chk({7'h0, irq}, 8'h01);
      @(posedge ref_clk);
      pll1_locked <= 1'b1;
      step(2);
      chk({6'h0, sticky, irq}, 8'h03);
      wr(8'h81, 8'h01);
      step(1);
      chk({6'h0, sticky, irq}, 8'h00);
      wr(8'h82, 8'h00);
      @(posedge ref_clk);
      pll1_locked <= 1'b0;
      step(2);
      chk({7'h0, irq}, 8'h00);
      rd(8'h81, 8'h01);
      pll1_locked <= 1'b1;
      wr(8'h81, 8'hFF);
   endtask : t_irq

   task automatic t_mask;
      @(posedge ref_clk);
      ref_sel    <= 2'h2;
      ref_active <= 4'hB;
      step(1);
      chk({6'h0, live, lock_pin}, 8'h02);
      rd(8'h83, 8'h03);
      wr(8'h80, 8'h10);
      step(1);
      chk({6'h0, live, lock_pin}, 8'h01);
      @(posedge ref_clk);
      pll1_locked <= 1'b0;
      step(1);
      chk({6'h0, live, lock_pin}, 8'h02);
      pll1_locked <= 1'b1;
      ref_active  <= 4'hF;
      ref_sel     <= 2'h0;
      wr(8'h80, 8'h00);
   endtask : t_mask

   task automatic t_sysref;
      wr(8'h1C, 8'h03);
      chk({6'h0, sr.trigger_gen, sr.trigger_out}, 8'h03);
      wr(8'h18, 8'hAF);
      step(1);
      chk({5'h0, sr.powerdown, sr.trigger_gen, sr.trigger_out}, 8'h04);
      wr(8'h70, 8'h80);
      chk({7'h0, req}, 8'h00);
      wr(8'h18, 8'h2F);
      wr(8'h70, 8'h80);
      chk({7'h0, req}, 8'h01);
      step(1);
      chk({7'h0, req}, 8'h00);
      rd(8'h70, 8'h00);
      rd(8'h1C, 8'h03);
      // Plain fields must reach the SYSREF carrier unchanged
      chk({1'b0, sr.freq_divider}, 8'h2F);
      chk(sr.bias_release, 8'h81);
      wr(8'h1A, 8'h5A);
      wr(8'h1B, 8'hA5);
      chk(sr.pulse_count, 8'h5A);
      chk(sr.phase_delay, 8'hA5);
      rd(8'h1B, 8'hA5);
   endtask : t_sysref

   //------------------------------------------------------------
   // Run control
   //------------------------------------------------------------
   task automatic end_of_test;
      $display("Summary: %0d checks, %0d errors", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      t_reset();
      t_ref_pd();
      t_irq();
      t_mask();
      t_sysref();
      end_of_test();
   end

   // Tests need about 100 cycles; 4000 means a hang
   initial begin
      repeat (4000) @(posedge ref_clk);
      errors++;
      end_of_test();
   end
endmodule : ref_input_and_sysref_ctrl_regs_tb_top
